/* File: exec_unit.sv */
// Branch, table, watchdog and arithmetic instruction execution unit
// Summary of operation
// - A taken skip adds one instruction cycle of four clocks.
// - Writing the pc low byte adds one instruction cycle.
// - Memory increment/decrement skips add both extra cycles independently.
// - Zero skips test a byte; loading form copies it to work; no flags.
// - Bit skips test bit i; skip on zero or on one.
// - Work-form inc/dec skips load work, keep memory, skip on zero.
// - Branch, call and the three exits take two cycles, no flags.
// - Call pushes next address then loads the target.
// - Current-page table read: low byte to memory, high to latch, two cycles.
// - Last-page table read: low byte to memory, high to latch, two cycles.
// - Watchdog clear zeroes the counter, clears timeout and power-down flags.
// - Pre-clears clear both flags only when the watchdog is cleared.
// - Power-down takes one cycle and affects timeout and power-down flags.
// - Nibble swap; work form loads work and leaves memory alone.
// - Byte clear writes zeros, no flags.
// - Bit clear zeroes bit i only, no flags.
// - Sum with carry into work updates four arithmetic flags.
// - Sum with carry into memory updates four arithmetic flags.
// - Plain sum into work or memory updates four arithmetic flags.
// - Conjunction into work updates only zero.
// - Conjunction into memory updates only zero.
// - Power-down halts, clears watchdog, sets power-down, clears timeout.
// - Interrupt exit pops the pc and sets global interrupt enable.
`timescale 1ns/10ps
module exec_unit #(
    parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic START,
    input wire exec_pkg::instr_t INSTR,
    input wire logic [7:0] MEM_RDATA,
    input wire logic [15:0] ROM_DATA,
    input wire logic WD_TIMEOUT,
    input wire logic WAKE,
    output exec_pkg::flags_t FLAGS,
    output logic [7:0] ACC,
    output logic [exec_pkg::PC_W-1:0] PC,
    output logic [7:0] TABLE_HIGH,
    output exec_pkg::mem_wr_t MEM_WR,
    output logic [exec_pkg::PC_W-1:0] ROM_ADDR,
    output logic ROM_RD,
    output logic WD_CLEAR,
    output logic HALTED,
    output logic GIE,
    output logic BUSY,
    output logic DONE
);

    localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
    localparam int PW = exec_pkg::PC_W;

    // Elaboration check of the stack depth
    if (STACK_DEPTH < 2 || STACK_DEPTH != (1 << SP_W)) begin
        $error("STACK_DEPTH must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [STACK_DEPTH-1:0][PW-1:0] stack;
        logic [SP_W-1:0] sp;
        logic [PW-1:0] pc;
        logic [7:0] acc;
        exec_pkg::flags_t flags;
        logic [7:0] table_high_latch;
        exec_pkg::mem_wr_t mem_wr;
        logic [PW-1:0] rom_addr;
        logic rom_rd;
        logic tbl_pend;
        logic [7:0] tbl_addr;
        logic pre_first;
        logic pre_second;
        logic wd_clr;
        logic global_irq_enable;
        logic halted;
        logic busy;
        logic [3:0] clk_left;
        logic done;
        logic wake_meta;
        logic wake_sync;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    function automatic logic [PW-1:0] with_low(input logic [PW-1:0] p,
                                               input logic [7:0] lo);
        return {p[PW-1:8], lo};
    endfunction

    logic accept;
    assign accept = START && !st.busy && !st.halted && !st.tbl_pend;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [8:0] sum9;
        logic [4:0] nib;
        logic [7:0] a;
        logic [7:0] m;
        logic [7:0] res;
        logic cin;
        logic skip;
        logic wr;
        logic arith;
        logic [1:0] ncyc;
        logic [PW-1:0] pc1;
        a = st.acc;
        m = MEM_RDATA;
        res = 8'h00;
        cin = 1'b0;
        skip = 1'b0;
        wr = 1'b0;
        arith = 1'b0;
        ncyc = 2'd1;
        pc1 = PW'(st.pc + 1'b1);
        sum9 = 9'h000;
        nib = 5'h00;
        next_st = st;
        next_st.mem_wr.en = 1'b0;
        next_st.rom_rd = 1'b0;
        next_st.wd_clr = 1'b0;
        next_st.done = 1'b0;
        next_st.wake_meta = WAKE;
        next_st.wake_sync = st.wake_meta;
        if (st.halted && st.wake_sync) begin
            next_st.halted = 1'b0;
        end
        if (st.busy) begin
            next_st.clk_left = 4'(st.clk_left - 1'b1);
            if (st.clk_left == 4'h0) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
        if (st.tbl_pend) begin
            // ROM word arrives one clock after the address
            next_st.tbl_pend = 1'b0;
            next_st.mem_wr = '{1'b1, st.tbl_addr, ROM_DATA[7:0]};
            next_st.table_high_latch = ROM_DATA[15:8];
            if (st.tbl_addr == exec_pkg::PC_LOW_ADDR) begin
                next_st.pc = with_low(st.pc, ROM_DATA[7:0]);
            end
        end
        if (accept) begin
            next_st.pc = pc1;
            unique case (INSTR.op)
                exec_pkg::OP_IDLE: begin
                end
                exec_pkg::OP_BRANCH: begin
                    ncyc = 2'd2;
                    next_st.pc = INSTR.target;
                end
                exec_pkg::OP_SKIP_ZERO: begin
                    skip = is_zero(m);
                end
                exec_pkg::OP_SKIP_ZERO_LOAD: begin
                    skip = is_zero(m);
                    next_st.acc = m;
                end
                exec_pkg::OP_SKIP_BIT_CLR: begin
                    skip = !m[INSTR.bit_sel];
                end
                exec_pkg::OP_SKIP_BIT_SET: begin
                    skip = m[INSTR.bit_sel];
                end
                exec_pkg::OP_SKIP_INC, exec_pkg::OP_SKIP_DEC: begin
                    res = (INSTR.op == exec_pkg::OP_SKIP_INC) ? 8'(m + 1'b1)
                                                              : 8'(m - 1'b1);
                    skip = is_zero(res);
                    wr = 1'b1;
                end
                exec_pkg::OP_SKIP_INC_WORK, exec_pkg::OP_SKIP_DEC_WORK: begin
                    res = (INSTR.op == exec_pkg::OP_SKIP_INC_WORK) ? 8'(m + 1'b1)
                                                                   : 8'(m - 1'b1);
                    skip = is_zero(res);
                    next_st.acc = res;
                end
                exec_pkg::OP_CALL: begin
                    ncyc = 2'd2;
                    next_st.stack[st.sp] = pc1;
                    next_st.sp = SP_W'(st.sp + 1'b1);
                    next_st.pc = INSTR.target;
                end
                exec_pkg::OP_SUB_EXIT, exec_pkg::OP_SUB_EXIT_IMM,
                exec_pkg::OP_IRQ_EXIT: begin
                    ncyc = 2'd2;
                    next_st.sp = SP_W'(st.sp - 1'b1);
                    next_st.pc = st.stack[SP_W'(st.sp - 1'b1)];
                    if (INSTR.op == exec_pkg::OP_SUB_EXIT_IMM) begin
                        next_st.acc = INSTR.imm;
                    end
                    if (INSTR.op == exec_pkg::OP_IRQ_EXIT) begin
                        next_st.global_irq_enable = 1'b1;
                    end
                end
                exec_pkg::OP_TABLE_CUR, exec_pkg::OP_TABLE_LAST: begin
                    ncyc = 2'd2;
                    next_st.tbl_pend = 1'b1;
                    next_st.tbl_addr = INSTR.addr;
                    next_st.rom_rd = 1'b1;
                    next_st.rom_addr = (INSTR.op == exec_pkg::OP_TABLE_CUR)
                        ? with_low(st.pc, INSTR.imm)
                        : {exec_pkg::LAST_PAGE, INSTR.imm};
                end
                exec_pkg::OP_CLEAR_BYTE: begin
                    res = 8'h00;
                    wr = 1'b1;
                end
                exec_pkg::OP_SET_BYTE: begin
                    res = 8'hff;
                    wr = 1'b1;
                end
                exec_pkg::OP_CLEAR_BIT: begin
                    res = m & ~(8'h01 << INSTR.bit_sel);
                    wr = 1'b1;
                end
                exec_pkg::OP_WD_CLEAR: begin
                    next_st.wd_clr = 1'b1;
                    next_st.flags.watchdog_timeout_flag = 1'b0;
                    next_st.flags.power_down_flag = 1'b0;
                    next_st.pre_first = 1'b0;
                    next_st.pre_second = 1'b0;
                end
                exec_pkg::OP_WD_PRE1, exec_pkg::OP_WD_PRE2: begin
                    // Counter clears only once both halves were executed
                    if ((INSTR.op == exec_pkg::OP_WD_PRE1) ? st.pre_second
                                                           : st.pre_first) begin
                        next_st.wd_clr = 1'b1;
                        next_st.flags.watchdog_timeout_flag = 1'b0;
                        next_st.flags.power_down_flag = 1'b0;
                        next_st.pre_first = 1'b0;
                        next_st.pre_second = 1'b0;
                    end else if (INSTR.op == exec_pkg::OP_WD_PRE1) begin
                        next_st.pre_first = 1'b1;
                    end else begin
                        next_st.pre_second = 1'b1;
                    end
                end
                exec_pkg::OP_SWAP_MEM: begin
                    res = {m[3:0], m[7:4]};
                    wr = 1'b1;
                end
                exec_pkg::OP_SWAP_WORK: begin
                    next_st.acc = {m[3:0], m[7:4]};
                end
                exec_pkg::OP_POWER_DOWN: begin
                    next_st.halted = 1'b1;
                    next_st.wd_clr = 1'b1;
                    next_st.flags.power_down_flag = 1'b1;
                    next_st.flags.watchdog_timeout_flag = 1'b0;
                end
                exec_pkg::OP_SUM_CARRY, exec_pkg::OP_SUM_CARRY_MEM,
                exec_pkg::OP_SUM, exec_pkg::OP_SUM_IMM,
                exec_pkg::OP_SUM_MEM: begin
                    arith = 1'b1;
                    if (INSTR.op == exec_pkg::OP_SUM_IMM) begin
                        m = INSTR.imm;
                    end
                    if (INSTR.op == exec_pkg::OP_SUM_CARRY ||
                        INSTR.op == exec_pkg::OP_SUM_CARRY_MEM) begin
                        cin = st.flags.carry;
                    end
                    sum9 = {1'b0, a} + {1'b0, m} + {8'h00, cin};
                    nib = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
                    res = sum9[7:0];
                    next_st.flags.carry = sum9[8];
                    next_st.flags.aux_carry_flag = nib[4];
                    next_st.flags.sign_wrap_flag = (a[7] == m[7]) && (res[7] != a[7]);
                    if (INSTR.op == exec_pkg::OP_SUM_CARRY_MEM ||
                        INSTR.op == exec_pkg::OP_SUM_MEM) begin
                        wr = 1'b1;
                    end else begin
                        next_st.acc = res;
                    end
                end
                exec_pkg::OP_CONJ, exec_pkg::OP_CONJ_IMM,
                exec_pkg::OP_CONJ_MEM: begin
                    arith = 1'b1;
                    res = a & ((INSTR.op == exec_pkg::OP_CONJ_IMM) ? INSTR.imm : m);
                    if (INSTR.op == exec_pkg::OP_CONJ_MEM) begin
                        wr = 1'b1;
                    end else begin
                        next_st.acc = res;
                    end
                end
                default: begin
                end
            endcase
            if (arith) begin
                next_st.flags.zero = is_zero(res);
            end
            if (wr) begin
                next_st.mem_wr = '{1'b1, INSTR.addr, res};
                if (INSTR.addr == exec_pkg::PC_LOW_ADDR) begin
                    next_st.pc = with_low(st.pc, res);
                end
            end
            if ((wr || INSTR.op == exec_pkg::OP_TABLE_CUR ||
                 INSTR.op == exec_pkg::OP_TABLE_LAST) &&
                INSTR.addr == exec_pkg::PC_LOW_ADDR) begin
                ncyc = 2'(ncyc + 1'b1);
            end
            if (skip) begin
                next_st.pc = PW'(st.pc + 2'd2);
                ncyc = 2'(ncyc + 1'b1);
            end
            next_st.busy = 1'b1;
            next_st.clk_left = 4'(ncyc * exec_pkg::CLKS_PER_CYCLE - 1);
        end
        // Timeout event wins over any clear in the same clock
        if (WD_TIMEOUT) begin
            next_st.flags.watchdog_timeout_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st <= '0;
            st.pc <= exec_pkg::PC_RESET;
            st.acc <= exec_pkg::ACC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign FLAGS = st.flags;
    assign ACC = st.acc;
    assign PC = st.pc;
    assign TABLE_HIGH = st.table_high_latch;
    assign MEM_WR = st.mem_wr;
    assign ROM_ADDR = st.rom_addr;
    assign ROM_RD = st.rom_rd;
    assign WD_CLEAR = st.wd_clr;
    assign HALTED = st.halted;
    assign GIE = st.global_irq_enable;
    assign BUSY = st.busy;
    assign DONE = st.done;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    sequence one_cycle;
        BUSY [*4] ##1 !BUSY;
    endsequence
    sequence two_cycles;
        BUSY [*8] ##1 !BUSY;
    endsequence
    sequence three_cycles;
        BUSY [*8] ##1 BUSY [*4] ##1 !BUSY;
    endsequence

    logic not_pcl;
    assign not_pcl = INSTR.addr != exec_pkg::PC_LOW_ADDR;

    skip_extra_a: assert property (accept && INSTR.op == exec_pkg::OP_SKIP_ZERO
        && is_zero(MEM_RDATA) |=> two_cycles) else $error("taken skip not two cycles");
    pcl_extra_a: assert property (accept && INSTR.op == exec_pkg::OP_CLEAR_BYTE
        && !not_pcl |=> two_cycles) else $error("pc low write lacks extra cycle");
    both_extra_a: assert property (accept && INSTR.op == exec_pkg::OP_SKIP_INC
        && !not_pcl && MEM_RDATA == 8'hff |=> three_cycles) else $error("inc skip not three");
    clear_one_a: assert property (accept && INSTR.op == exec_pkg::OP_CLEAR_BYTE
        && not_pcl |=> one_cycle and MEM_WR.en && MEM_WR.data == 8'h00)
        else $error("byte clear wrong");
    branch_two_a: assert property (accept && INSTR.op == exec_pkg::OP_BRANCH
        |=> PC == $past(INSTR.target) && FLAGS == $past(FLAGS) ##0 two_cycles)
        else $error("branch wrong");
    call_push_a: assert property (accept && INSTR.op == exec_pkg::OP_CALL
        |=> st.stack[$past(st.sp)] == PW'($past(PC) + 1'b1) && PC == $past(INSTR.target))
        else $error("call push wrong");
    wd_clear_a: assert property (accept && INSTR.op == exec_pkg::OP_WD_CLEAR
        && !WD_TIMEOUT |=> WD_CLEAR && !FLAGS.watchdog_timeout_flag && !FLAGS.power_down_flag)
        else $error("watchdog clear wrong");
    swap_work_a: assert property (accept && INSTR.op == exec_pkg::OP_SWAP_WORK
        |=> ACC == {$past(MEM_RDATA[3:0]), $past(MEM_RDATA[7:4])} && !MEM_WR.en)
        else $error("swap to work wrong");
    conj_imm_a: assert property (accept && INSTR.op == exec_pkg::OP_CONJ_IMM
        |=> ACC == ($past(ACC) & $past(INSTR.imm)) && FLAGS.zero == is_zero(ACC)
        && FLAGS.carry == $past(FLAGS.carry)) else $error("conjunction wrong");
    power_down_a: assert property (accept && INSTR.op == exec_pkg::OP_POWER_DOWN
        && !WD_TIMEOUT |=> HALTED && FLAGS.power_down_flag && !FLAGS.watchdog_timeout_flag
        && WD_CLEAR ##0 one_cycle) else $error("power down wrong");
    sum_carry_a: assert property (accept && INSTR.op == exec_pkg::OP_SUM_CARRY
        |=> ACC == 8'($past(ACC) + $past(MEM_RDATA) + $past(FLAGS.carry)))
        else $error("sum with carry wrong");
    table_read_a: assert property (accept && INSTR.op == exec_pkg::OP_TABLE_LAST
        |=> ROM_RD ##1 MEM_WR.en && TABLE_HIGH == $past(ROM_DATA[15:8]))
        else $error("table read wrong");

endmodule

/* File: exec_pkg.sv */
// Shared types and constants of the instruction execution unit
package exec_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int CLOCK_NS = 100;
    localparam int CYCLE_CLKS = 4;
    localparam int CYCLE_NS = 400;
    localparam int CLKS_PER_CYCLE = (CYCLE_NS + CLOCK_NS - 1) / CLOCK_NS;

    // ------------------------------------------------------------
    // Addresses and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PC_LOW_ADDR = 8'h06;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-9:0] LAST_PAGE = 5'h1f;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_IDLE, OP_BRANCH, OP_SKIP_ZERO, OP_SKIP_ZERO_LOAD,
        OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET, OP_SKIP_INC, OP_SKIP_DEC,
        OP_SKIP_INC_WORK, OP_SKIP_DEC_WORK, OP_CALL, OP_SUB_EXIT,
        OP_SUB_EXIT_IMM, OP_IRQ_EXIT, OP_TABLE_CUR, OP_TABLE_LAST,
        OP_CLEAR_BYTE, OP_SET_BYTE, OP_CLEAR_BIT, OP_WD_CLEAR,
        OP_WD_PRE1, OP_WD_PRE2, OP_SWAP_MEM, OP_SWAP_WORK,
        OP_POWER_DOWN, OP_SUM_CARRY, OP_SUM_CARRY_MEM, OP_SUM,
        OP_SUM_IMM, OP_SUM_MEM, OP_CONJ, OP_CONJ_IMM, OP_CONJ_MEM
    } op_t;

    typedef struct packed {
        op_t op;
        logic [7:0] addr;
        logic [7:0] imm;
        logic [2:0] bit_sel;
        logic [PC_W-1:0] target;
    } instr_t;

    typedef struct packed {
        logic watchdog_timeout_flag;
        logic power_down_flag;
        logic sign_wrap_flag;
        logic zero;
        logic aux_carry_flag;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_wr_t;

endpackage

/* File: core_mem_model.sv */
// Data memory and program ROM model facing the execution unit
`timescale 1ns/10ps
module core_mem_model (
    input wire logic CLOCK,
    input wire logic [7:0] RD_ADDR,
    output logic [7:0] RDATA,
    input wire exec_pkg::mem_wr_t WR,
    input wire logic [12:0] ROM_ADDR,
    input wire logic ROM_RD,
    output logic [15:0] ROM_DATA
);
    logic [7:0] mem [256];
    logic rd_d = 1'b0;
    logic [15:0] churn = 16'h0;
    assign RDATA = mem[RD_ADDR];
    // Word stands with the strobe and one clock after, churns otherwise
    assign ROM_DATA = (ROM_RD | rd_d) ?
        {ROM_ADDR[7:0] ^ {ROM_ADDR[12:8], 3'h0}, ~ROM_ADDR[7:0]} : churn;
    always @(posedge CLOCK) begin
        rd_d <= ROM_RD;
        churn <= churn + 16'h9e37;
        if (WR.en === 1'b1) begin
            mem[WR.addr] <= WR.data;
        end
    end
endmodule

/* File: mcu_branch_misc_arith_exec_tb.sv */
// Self-checking bench of the execution unit
`timescale 1ns/10ps
module mcu_branch_misc_arith_exec_tb;
    typedef struct packed {
        logic [7:0] acc;
        logic [12:0] pc;
        exec_pkg::flags_t fl;
        logic [3:0] cl;
        logic [1:0] wd;
        logic [7:0] ma;
        logic [7:0] md;
        logic [7:0] th;
        logic gie;
        logic hl;
    } note_t;
    logic clock, sys_rst, start, wd_to, wake, rom_rd, wd_clear, halted, gie, busy, done;
    logic e_gie, e_hl, tk;
    exec_pkg::instr_t instr;
    exec_pkg::flags_t flags, e_fl;
    exec_pkg::mem_wr_t mem_wr;
    exec_pkg::op_t op;
    logic [7:0] mem_rdata, acc, th, e_acc, md, e_th, v, i, r;
    logic [12:0] pc, rom_addr, e_pc, tp;
    logic [15:0] rom_data;
    note_t q[$];
    note_t got, ex;
    int n_fail, checks_done, nbusy, nwd, cyc;
    exec_unit uut (.CLOCK(clock), .SYS_RST(sys_rst), .START(start), .INSTR(instr),
        .MEM_RDATA(mem_rdata), .ROM_DATA(rom_data), .WD_TIMEOUT(wd_to), .WAKE(wake),
        .FLAGS(flags), .ACC(acc), .PC(pc), .TABLE_HIGH(th), .MEM_WR(mem_wr),
        .ROM_ADDR(rom_addr), .ROM_RD(rom_rd), .WD_CLEAR(wd_clear), .HALTED(halted),
        .GIE(gie), .BUSY(busy), .DONE(done));
    core_mem_model mdl (.CLOCK(clock), .RD_ADDR(instr.addr), .RDATA(mem_rdata),
        .WR(mem_wr), .ROM_ADDR(rom_addr), .ROM_RD(rom_rd), .ROM_DATA(rom_data));
    task automatic cmp(input logic [63:0] g, input logic [63:0] x);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic setm(input logic [7:0] a, input logic [7:0] d);
        mdl.mem[a] = d;
        md = d;
    endtask
    task automatic run(input exec_pkg::op_t o, input logic [7:0] a, input logic [7:0] im,
            input logic [2:0] b, input logic [12:0] t, input int n, input logic [1:0] w);
        int k;
        q.push_back('{e_acc, e_pc, e_fl, 4'(n * 4), w, a, md, e_th, e_gie, e_hl});
        instr <= '{o, a, im, b, t};
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (done !== 1'b1 && k < 40);
        if (done !== 1'b1) cmp(1, 0);
        @(posedge clock);
        $display("step %s finished", o.name());
    endtask
    function automatic void alu(input logic [7:0] b, input logic c, input logic m, input logic lg);
        logic [8:0] s;
        s = lg ? {1'b0, e_acc & b} : e_acc + b + c;
        if (!lg) begin
            e_fl.carry = s[8];
            e_fl.aux_carry_flag = e_acc[3:0] + b[3:0] + c > 5'h0f;
            e_fl.sign_wrap_flag = e_acc[7] == b[7] && s[7] != e_acc[7];
        end
        e_fl.zero = s[7:0] == 8'h00;
        if (m) md = s[7:0];
        else e_acc = s[7:0];
    endfunction
    always @(negedge clock) begin
        if (busy === 1'b1) nbusy++;
        if (wd_clear === 1'b1) nwd++;
        if (done === 1'b1 && q.size() > 0) begin
            ex = q.pop_front();
            got = '{acc, pc, flags, nbusy[3:0], nwd[1:0], ex.ma, mdl.mem[ex.ma], th, gie, halted};
            cmp(got, ex);
            nbusy = 0;
            nwd = 0;
        end else if (done === 1'b1) cmp(1, 0);
    end
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 4000) begin
            cmp(1, 0);
            conclude();
        end
    end
    initial begin
        {sys_rst, start, wd_to, wake} = 4'h8;
        instr = '0;
        {e_acc, e_pc, e_fl, e_th, e_gie, e_hl, md} = '0;
        {n_fail, checks_done, nbusy, nwd, cyc} = '0;
        void'($urandom(32'hcedf51c1));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        cmp({acc, pc, flags, th, gie, busy, halted}, '0);
        @(posedge clock);
        for (int k = 0; k < 4; k++) begin
            setm(8'h20, k[0] ? 8'h00 : 8'h5a);
            if (k[1]) e_acc = md;
            tk = md == 8'h00;
            e_pc += 13'h1 + tk;
            run(exec_pkg::op_t'(int'(exec_pkg::OP_SKIP_ZERO) + k / 2), 8'h20, 0, 0, 0, 1 + tk, 0);
        end
        for (int k = 0; k < 8; k++) begin
            v = $urandom;
            for (int s = 0; s < 3; s++) begin
                setm(8'h21, v);
                tk = s < 2 && v[k] == s[0];
                if (s == 2) md = v & ~(8'h01 << k);
                op = s == 2 ? exec_pkg::OP_CLEAR_BIT : exec_pkg::op_t'(int'(exec_pkg::OP_SKIP_BIT_CLR) + s);
                e_pc += 13'h1 + tk;
                run(op, 8'h21, 0, 3'(k), 0, 1 + tk, 0);
            end
        end
        for (int k = 0; k < 5; k++) begin
            op = exec_pkg::op_t'(int'(exec_pkg::OP_SKIP_INC) + k % 4);
            setm(8'h22, k == 4 ? 8'h03 : (k % 2 ? 8'h01 : 8'hff));
            r = k % 2 ? md - 8'h1 : md + 8'h1;
            if (op >= exec_pkg::OP_SKIP_INC_WORK) e_acc = r;
            else md = r;
            e_pc += 13'h1 + (r == 8'h00);
            run(op, 8'h22, 0, 0, 0, 1 + (r == 8'h00), 0);
        end
        setm(exec_pkg::PC_LOW_ADDR, 8'hff);
        md = 8'h00;
        e_pc += 13'h2;
        run(exec_pkg::OP_SKIP_INC, exec_pkg::PC_LOW_ADDR, 0, 0, 0, 3, 0);
        setm(8'h00, 8'h00);
        e_pc = 13'h0abc;
        run(exec_pkg::OP_BRANCH, 0, 0, 0, 13'h0abc, 2, 0);
        for (int k = 0; k < 3; k++) begin
            tp = e_pc + 13'h1;
            e_pc = 13'h1234;
            run(exec_pkg::OP_CALL, 0, 0, 0, 13'h1234, 2, 0);
            e_pc = tp;
            if (k == 1) e_acc = 8'hc3;
            if (k == 2) e_gie = 1'b1;
            run(exec_pkg::op_t'(int'(exec_pkg::OP_SUB_EXIT) + k), 0, 8'hc3, 0, 0, 2, 0);
        end
        for (int k = 0; k < 2; k++) begin
            i = $urandom;
            r = k ? 8'hf8 : {e_pc[12:8], 3'h0};
            setm(8'h40, 8'h99);
            md = ~i;
            e_th = i ^ r;
            e_pc += 13'h1;
            run(exec_pkg::op_t'(int'(exec_pkg::OP_TABLE_CUR) + k), 8'h40, i, 0, 0, 2, 0);
        end
        setm(8'h50, 8'h77);
        md = 8'h00;
        e_pc += 13'h1;
        run(exec_pkg::OP_CLEAR_BYTE, 8'h50, 0, 0, 0, 1, 0);
        for (int k = 0; k < 2; k++) begin
            setm(exec_pkg::PC_LOW_ADDR, 8'h77);
            md = k ? 8'hff : 8'h00;
            e_pc = {e_pc[12:8], md};
            op = exec_pkg::op_t'(int'(exec_pkg::OP_CLEAR_BYTE) + k);
            run(op, exec_pkg::PC_LOW_ADDR, 0, 0, 0, 2, 0);
        end
        v = $urandom;
        setm(8'h52, v);
        md = {v[3:0], v[7:4]};
        e_pc += 13'h1;
        run(exec_pkg::OP_SWAP_MEM, 8'h52, 0, 0, 0, 1, 0);
        e_acc = v;
        e_pc += 13'h1;
        run(exec_pkg::OP_SWAP_WORK, 8'h52, 0, 0, 0, 1, 0);
        md = 8'h00;
        for (int k = 0; k < 5; k++) begin
            wd_to <= 1'b1;
            @(posedge clock);
            wd_to <= 1'b0;
            e_fl.watchdog_timeout_flag = 1'b1;
            op = k == 0 ? exec_pkg::OP_POWER_DOWN : (k == 1 ? exec_pkg::OP_WD_CLEAR :
                (k == 4 ? exec_pkg::OP_WD_PRE2 : exec_pkg::OP_WD_PRE1));
            tk = k < 2 || k == 4;
            if (tk) e_fl[5:4] = {1'b0, k == 0};
            e_hl = k == 0;
            e_pc += 13'h1;
            run(op, 0, 0, 0, 0, 1, tk);
            if (k == 0) begin
                wake <= 1'b1;
                repeat (6) @(posedge clock);
                wake <= 1'b0;
            end
        end
        for (int k = 0; k < 32; k++) begin
            op = exec_pkg::op_t'(int'(exec_pkg::OP_SUM_CARRY) + k % 8);
            v = k < 8 ? -e_acc : 8'($urandom);
            i = k < 8 ? -e_acc : 8'($urandom);
            setm(8'h30, v);
            alu(op == exec_pkg::OP_SUM_IMM || op == exec_pkg::OP_CONJ_IMM ? i : v,
                k % 8 < 2 ? e_fl.carry : 1'b0, k % 8 == 1 || k % 8 == 4 || k % 8 == 7, k % 8 > 4);
            e_pc += 13'h1;
            run(op, 8'h30, i, 0, 0, 1, 0);
        end
        conclude();
    end
endmodule
